//--- hdl/eph_pkg.sv
// Constants for the parallel port handshake engine
package eph_pkg;
	localparam int CLK_PERIOD_NS = 50;
	// Glitch filter: input must be stable 75..130 ns
	localparam int FILTER_MIN_NS = 75;
	localparam int FILTER_CYC    = (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Compatible-mode strobe timing
	localparam int DATA_SETUP_NS = 600;
	localparam int STB_WIDTH_NS  = 600;
	localparam int DATA_HOLD_NS  = 450;
	localparam int BUSY_GAP_NS   = 680;
	localparam int SETUP_CYC     = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WIDTH_CYC     = (STB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC      = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC       = (BUSY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ECP response limit after a filtered edge
	localparam int RESP_MAX_NS   = 200;
	localparam int RESP_CYC      = RESP_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 5;
	localparam logic [1:0] MODE_COMPAT_FIFO = 2'h0;
	localparam logic [1:0] MODE_ECP         = 2'h1;
	localparam logic [1:0] MODE_EPP         = 2'h2;

	typedef enum logic [2:0] {
		EPH_IDLE    = 3'b000,
		EPH_SETUP   = 3'b001,
		EPH_STROBE  = 3'b010,
		EPH_RELEASE = 3'b011,
		EPH_HOLD    = 3'b100,
		EPH_REV_ACK = 3'b101,
		EPH_REV_END = 3'b110
	} eph_state_t;
endpackage

//--- hdl/eph_engine.sv
// Parallel port transfer engine: compatible FIFO mode and ECP handshakes
// Notes on behaviour
// - In compatible FIFO mode forward bytes are paced by Busy alone and acknowledge is ignored; the code also times setup, strobe width, hold and gap.
// - In forward idle the strobe stays high and the peripheral keeps Busy low.
// - Forward byte: wait Busy low, drive data, drop strobe, Busy rises, raise strobe, Busy falls.
// - A Busy change counts only after it has been stable for the filter interval.
// - In ECP mode, with a byte waiting the next strobe starts within 200 ns of Busy seen low; else it waits.
// - In reverse idle the peripheral keeps acknowledge high and the port keeps host-ack low.
// - Reverse byte: host-ack low, ack falls, host-ack rises, ack rises, byte taken, host-ack low.
// - Reverse transfers stall with host-ack low while the FIFO is full or terminal count is in.
// - An acknowledge change counts only after it has been stable for the filter interval.
// - Compatible data holds until Busy falls or the hold time passes, whichever is later.
// - Lines use push-pull drivers in ECP mode, open collector otherwise, switched glitch free; the code drives the data lines push-pull in every mode.
// - The EPP write/read line follows the port direction bit, set to one for reads.
`timescale 1ns/1ps
module eph_engine (
	input  wire logic       clk,                // 20 MHz clock
	input  wire logic       rst_b,              // Async reset, active low
	input  wire logic [1:0] mode,               // Port mode select
	input  wire logic       port_direction_bit, // 1 = reverse / EPP read
	input  wire logic [7:0] tx_data,            // FIFO head byte
	input  wire logic       tx_valid,           // FIFO holds a byte
	output logic            tx_ready,           // Pop pulse for FIFO head
	output logic [7:0]      rx_data,            // Captured reverse byte
	output logic            rx_valid,           // Push pulse for reverse byte
	input  wire logic       rx_room,            // FIFO can take a byte
	input  wire logic       term_count,         // DMA terminal count seen
	input  wire logic       busy_in,            // Busy / PeriphAck pin
	input  wire logic       ack_n_in,           // nAck / PeriphClk pin
	input  wire logic       fault_n_in,         // nFault / nPeriphRequest pin
	input  wire logic [7:0] cable_data_in,      // Data pins, input side
	output logic [7:0]      cable_data_lines,   // Data pins, output value
	output logic [7:0]      cable_data_oe_b,    // Data pin enables, low drives
	output logic            strobe_n_out,       // nStrobe value
	output logic            strobe_oe_b,        // nStrobe enable, low drives
	output logic            autofd_n_out,       // nAutoFd value
	output logic            autofd_oe_b,        // nAutoFd enable, low drives
	output logic            epp_write_n,        // EPP write/read line
	output logic            periph_request      // Registered reverse request, forward direction only
);
	logic       busy_f, next_busy_f, ack_f, next_ack_f;
	logic [eph_pkg::CNT_W-1:0] busy_cnt, next_busy_cnt, ack_cnt, next_ack_cnt;
	logic [eph_pkg::CNT_W-1:0] cnt, next_cnt;
	eph_pkg::eph_state_t state, next_state;
	logic       next_tx_ready, next_rx_valid, next_strobe_n, next_autofd_n;
	logic [7:0] next_rx_data, next_data, next_data_oe_b;
	logic       next_strobe_oe_b, next_autofd_oe_b, next_epp_write_n, next_req;
	logic       ecp, compat;

	assign ecp    = (mode == eph_pkg::MODE_ECP);
	assign compat = (mode == eph_pkg::MODE_COMPAT_FIFO);

	// Stability filter: the new level is taken only after it persists
	function automatic logic [eph_pkg::CNT_W:0] filt(input logic pin, input logic cur,
		input logic [eph_pkg::CNT_W-1:0] c);
		if (pin == cur)
			filt = {cur, {eph_pkg::CNT_W{1'b0}}};
		else if (c >= eph_pkg::CNT_W'(eph_pkg::FILTER_CYC - 1))
			filt = {pin, {eph_pkg::CNT_W{1'b0}}};
		else
			filt = {cur, c + 1'b1};
	endfunction

	// Filtered handshake inputs
	always_comb begin
		{next_busy_f, next_busy_cnt} = filt(busy_in, busy_f, busy_cnt);
		{next_ack_f, next_ack_cnt}   = filt(ack_n_in, ack_f, ack_cnt);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_f   <= 1'b0;
			busy_cnt <= '0;
			ack_f    <= 1'b1;
			ack_cnt  <= '0;
		end else begin
			busy_f   <= next_busy_f;
			busy_cnt <= next_busy_cnt;
			ack_f    <= next_ack_f;
			ack_cnt  <= next_ack_cnt;
		end
	end

	// Transfer sequencer
	always_comb begin
		next_state     = state;
		next_cnt       = (cnt == '0) ? cnt : cnt - 1'b1;
		next_tx_ready  = 1'b0;
		next_rx_valid  = 1'b0;
		next_rx_data   = rx_data;
		next_data      = cable_data_lines;
		next_strobe_n  = strobe_n_out;
		next_autofd_n  = autofd_n_out;
		case (state)
			eph_pkg::EPH_IDLE: begin
				next_strobe_n = 1'b1;
				next_autofd_n = port_direction_bit ? 1'b0 : autofd_n_out;
				if (port_direction_bit && ecp) begin
					// Stall by leaving host-ack low
					if (!ack_f && rx_room && !term_count) begin
						next_autofd_n = 1'b1;
						next_state    = eph_pkg::EPH_REV_ACK;
					end
				end else if (!port_direction_bit && (ecp || compat) && tx_valid
					&& !busy_f && cnt == '0) begin
					next_data     = tx_data;
					next_tx_ready = 1'b1;
					if (ecp) begin
						next_strobe_n = 1'b0;
						next_state    = eph_pkg::EPH_STROBE;
					end else begin
						next_cnt   = eph_pkg::CNT_W'(eph_pkg::SETUP_CYC - 1);
						next_state = eph_pkg::EPH_SETUP;
					end
				end
			end
			eph_pkg::EPH_SETUP: begin
				if (cnt == '0) begin
					next_strobe_n = 1'b0;
					next_cnt      = eph_pkg::CNT_W'(eph_pkg::WIDTH_CYC - 1);
					next_state    = eph_pkg::EPH_STROBE;
				end
			end
			eph_pkg::EPH_STROBE: begin
				// ECP waits for Busy; compatible strobe is timed only
				if (ecp ? busy_f : (cnt == '0)) begin
					next_strobe_n = 1'b1;
					next_cnt      = eph_pkg::CNT_W'(eph_pkg::HOLD_CYC - 1);
					next_state    = ecp ? eph_pkg::EPH_RELEASE : eph_pkg::EPH_HOLD;
				end
			end
			eph_pkg::EPH_RELEASE: begin
				if (!busy_f) begin
					next_cnt   = '0;
					next_state = eph_pkg::EPH_IDLE;
				end
			end
			eph_pkg::EPH_HOLD: begin
				// Data stays on the pins until replaced by the next byte
				if (cnt == '0 && !busy_f) begin
					next_cnt   = eph_pkg::CNT_W'(eph_pkg::GAP_CYC - 1);
					next_state = eph_pkg::EPH_IDLE;
				end
			end
			eph_pkg::EPH_REV_ACK: begin
				if (ack_f) begin
					next_rx_data  = cable_data_in;
					next_rx_valid = 1'b1;
					next_autofd_n = 1'b0;
					next_state    = eph_pkg::EPH_REV_END;
				end
			end
			eph_pkg::EPH_REV_END: next_state = eph_pkg::EPH_IDLE;
			default: next_state = eph_pkg::EPH_IDLE;
		endcase
	end

	// Driver type and direction; push-pull enables are set only between transfers
	always_comb begin
		next_epp_write_n = port_direction_bit;
		next_req         = !fault_n_in && !port_direction_bit;
		next_data_oe_b   = port_direction_bit ? 8'hFF : 8'h00;
		next_strobe_oe_b = strobe_oe_b;
		next_autofd_oe_b = autofd_oe_b;
		if (state == eph_pkg::EPH_IDLE) begin
			// Open collector: enable only while pulling low
			next_strobe_oe_b = ecp ? 1'b0 : next_strobe_n;
			next_autofd_oe_b = ecp ? 1'b0 : next_autofd_n;
		end else if (!ecp) begin
			next_strobe_oe_b = next_strobe_n;
			next_autofd_oe_b = next_autofd_n;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state            <= eph_pkg::EPH_IDLE;
			cnt              <= '0;
			tx_ready         <= 1'b0;
			rx_valid         <= 1'b0;
			rx_data          <= 8'h00;
			cable_data_lines <= 8'h00;
			cable_data_oe_b  <= 8'hFF;
			strobe_n_out     <= 1'b1;
			strobe_oe_b      <= 1'b1;
			autofd_n_out     <= 1'b1;
			autofd_oe_b      <= 1'b1;
			epp_write_n      <= 1'b1;
			periph_request   <= 1'b0;
		end else begin
			state            <= next_state;
			cnt              <= next_cnt;
			tx_ready         <= next_tx_ready;
			rx_valid         <= next_rx_valid;
			rx_data          <= next_rx_data;
			cable_data_lines <= next_data;
			cable_data_oe_b  <= next_data_oe_b;
			strobe_n_out     <= next_strobe_n;
			strobe_oe_b      <= next_strobe_oe_b;
			autofd_n_out     <= next_autofd_n;
			autofd_oe_b      <= next_autofd_oe_b;
			epp_write_n      <= next_epp_write_n;
			periph_request   <= next_req;
		end
	end

	strobe_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_IDLE && $past(state) == eph_pkg::EPH_IDLE) |-> strobe_n_out)
		else $error("strobe low in idle");
	busy_filter_a: assert property (@(posedge clk) disable iff (!rst_b)
		$changed(busy_f) |-> $past(busy_in) == busy_f && $past(busy_in, 2) == busy_f)
		else $error("busy change not filtered");
	ack_filter_a: assert property (@(posedge clk) disable iff (!rst_b)
		$changed(ack_f) |-> $past(ack_n_in) == ack_f && $past(ack_n_in, 2) == ack_f)
		else $error("ack change not filtered");
	ecp_release_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_STROBE && ecp && busy_f) |=> strobe_n_out)
		else $error("strobe not released after busy");
	ecp_next_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_IDLE && ecp && !port_direction_bit && tx_valid && !busy_f
		&& cnt == '0) |=> !strobe_n_out && tx_ready)
		else $error("next strobe late");
	rev_stall_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_IDLE && (!rx_room || term_count)) |=>
		state != eph_pkg::EPH_REV_ACK)
		else $error("reverse not stalled");
	rev_respond_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_IDLE && ecp && port_direction_bit && !ack_f && rx_room
		&& !term_count) |=> autofd_n_out && state == eph_pkg::EPH_REV_ACK)
		else $error("reverse reply late");
	rev_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_REV_ACK && ack_f) |=> rx_valid && !autofd_n_out)
		else $error("reverse byte not captured");
	compat_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == eph_pkg::EPH_HOLD && busy_f) |=> state == eph_pkg::EPH_HOLD)
		else $error("data released while busy");
	open_drain_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!ecp && $past(!ecp) && !strobe_oe_b && state != eph_pkg::EPH_IDLE) |-> !strobe_n_out)
		else $error("open collector drives high");
	dir_line_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(port_direction_bit) |-> epp_write_n)
		else $error("direction line wrong");
endmodule

//--- testbench/eph_periph.sv
// Peripheral model on the far end of the cable
`timescale 1ns/1ps
module eph_periph (
	input  wire logic       clk,        // Clock
	input  wire logic       strobe_n,   // nStrobe pin
	input  wire logic       autofd_n,   // nAutoFd pin
	input  wire logic [7:0] data_pin,   // Data pins
	input  wire logic [3:0] delay,      // Reply delay
	input  wire logic [7:0] send_byte,  // Reverse byte
	input  wire logic [7:0] send_total, // Reverse bytes wanted
	output logic            busy,       // Busy pin
	output logic            ack_n,      // nAck pin
	output logic [7:0]      data_out,   // Reverse data
	output logic [7:0]      got_byte,   // Last byte taken
	output logic [7:0]      got_count,  // Bytes taken
	output logic [7:0]      sent        // Bytes sent
);
	initial begin
		busy = 1'b0;
		got_byte = 8'h00;
		got_count = 8'h00;
		forever begin
			@(negedge clk);
			if (!strobe_n) begin
				repeat (delay) @(negedge clk);
				busy = 1'b1;
				while (!strobe_n) @(negedge clk);
				got_byte = data_pin;
				got_count = got_count + 8'h01;
				repeat (delay) @(negedge clk);
				busy = 1'b0;
			end
		end
	end
	initial begin
		ack_n = 1'b1;
		data_out = 8'hA5;
		sent = 8'h00;
		forever begin
			@(negedge clk);
			if (sent != send_total) begin
				data_out = send_byte;
				ack_n = 1'b0;
				while (!autofd_n) @(negedge clk);
				repeat (delay) @(negedge clk);
				ack_n = 1'b1;
				while (autofd_n) @(negedge clk);
				// Stale data must not look valid
				data_out = ~send_byte;
				sent = sent + 8'h01;
			end
		end
	end
endmodule

//--- testbench/tb.sv
// Testbench for the parallel port transfer engine
`timescale 1ns/1ps
module tb;
	logic [1:0] mode;
	logic       clk = 1'b0;
	logic       rst_b, dir, rx_room, term_count, fault_n, tx_valid, tx_ready, rx_valid;
	logic       busy, ack_n, stb_n, stb_oe_b, afd_n, afd_oe_b, epp_w_n, preq;
	logic [7:0] fifo [0:7];
	logic [7:0] rev [0:7];
	logic [7:0] rx_q [$];
	logic [3:0] idx, fill, delay;
	logic [7:0] send_total, sent, got_byte, got_count, per_d, wire_d, d_lines, d_oe_b, rx_data;
	int         errors, compares;
	// Undriven pins carry the peripheral data in reverse, else float to the cable pull-ups
	assign wire_d = (d_lines & ~d_oe_b) | ((dir ? per_d : 8'hFF) & d_oe_b);
	assign tx_valid = (idx != fill);
	always @(posedge clk) begin
		if (!rst_b) begin
			idx <= 4'h0;
		end else if (tx_ready === 1'b1) begin
			idx <= idx + 4'h1;
		end
	end
	always @(posedge clk) if (rx_valid === 1'b1) rx_q.push_back(rx_data);
	eph_engine u_eph_engine (.clk(clk), .rst_b(rst_b), .mode(mode), .port_direction_bit(dir),
		.tx_data(fifo[idx[2:0]]), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_room(rx_room), .term_count(term_count), .busy_in(busy),
		.ack_n_in(ack_n), .fault_n_in(fault_n), .cable_data_in(wire_d),
		.cable_data_lines(d_lines), .cable_data_oe_b(d_oe_b), .strobe_n_out(stb_n),
		.strobe_oe_b(stb_oe_b), .autofd_n_out(afd_n), .autofd_oe_b(afd_oe_b),
		.epp_write_n(epp_w_n), .periph_request(preq));
	eph_periph u_eph_periph (.clk(clk), .strobe_n(stb_oe_b | stb_n), .autofd_n(afd_oe_b | afd_n),
		.data_pin(wire_d), .delay(delay), .send_byte(rev[sent[2:0]]), .send_total(send_total),
		.busy(busy), .ack_n(ack_n), .data_out(per_d), .got_byte(got_byte),
		.got_count(got_count), .sent(sent));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_fwd(input logic [7:0] n);
		for (int i = 0; i < 400 && got_count != n; i++) @(negedge clk);
		chk(got_count, n);
	endtask
	task automatic wait_pin(input logic v, input bit is_busy);
		for (int i = 0; i < 400 && (is_busy ? busy : stb_n) !== v; i++) @(negedge clk);
		chk({7'h00, (is_busy ? busy : stb_n)}, {7'h00, v});
	endtask
	task automatic t_fault();
		fault_n = 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h00, preq}, 8'h01);
		fault_n = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h00, preq}, 8'h00);
	endtask
	task automatic t_ecp_fwd();
		int         g;
		logic [7:0] c;
		c = got_count;
		fill = idx + 4'h3;
		wait_pin(1'b1, 1'b1);
		wait_pin(1'b0, 1'b1);
		for (g = 0; g < 40 && stb_n; g++) @(negedge clk);
		chk({7'h00, g <= eph_pkg::FILTER_CYC + eph_pkg::RESP_CYC}, 8'h01);
		wait_fwd(c + 8'h03);
		chk(got_byte, fifo[(idx[2:0] - 3'h1)]);
		repeat (8) @(negedge clk);
		chk({stb_n, stb_oe_b, 6'h00}, 8'h80);
	endtask
	task automatic t_compat();
		int         w;
		logic [7:0] b;
		mode = eph_pkg::MODE_COMPAT_FIFO;
		delay = 4'h2;
		b = fifo[idx[2:0]];
		fill = idx + 4'h2;
		wait_pin(1'b0, 1'b0);
		for (w = 0; w < 40 && !stb_n; w++) @(negedge clk);
		chk(8'(w), 8'(eph_pkg::WIDTH_CYC));
		repeat (8) @(negedge clk);
		chk(d_lines, b);
		for (w = 0; w < 400 && stb_n; w++) @(negedge clk);
		chk({7'h00, w >= eph_pkg::GAP_CYC - 8}, 8'h01);
		wait_fwd(got_count + 8'h01);
		chk(got_byte, fifo[(idx[2:0] - 3'h1)]);
		repeat (20) @(negedge clk);
		chk({stb_n, stb_oe_b, 6'h00}, 8'hC0);
	endtask
	task automatic t_rev();
		mode = eph_pkg::MODE_ECP;
		dir = 1'b1;
		delay = 4'h3;
		repeat (4) @(negedge clk);
		chk({afd_n, afd_oe_b, 6'h00}, 8'h00);
		chk(d_oe_b, 8'hFF);
		send_total = sent + 8'h02;
		for (int i = 0; i < 400 && rx_q.size() < 2; i++) @(negedge clk);
		chk(8'(rx_q.size()), 8'h02);
		chk(rx_q[1], rev[1]);
		rx_room = 1'b0;
		send_total = sent + 8'h01;
		repeat (20) @(negedge clk);
		chk({afd_n, 7'(rx_q.size())}, 8'h02);
		rx_room = 1'b1;
		term_count = 1'b1;
		repeat (20) @(negedge clk);
		chk({afd_n, 7'(rx_q.size())}, 8'h02);
		term_count = 1'b0;
		for (int i = 0; i < 400 && rx_q.size() < 3; i++) @(negedge clk);
		chk(8'(rx_q.size()), 8'h03);
		chk(rx_q[2], rev[2]);
		chk({7'h00, afd_n}, 8'h00);
	endtask
	task automatic wrap_up();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#500000;
		errors++;
		wrap_up();
	end
	initial begin
		{errors, compares, rst_b, dir, term_count, fill, delay, send_total} = '0;
		{rx_room, fault_n} = 2'h3;
		mode = eph_pkg::MODE_ECP;
		for (int i = 0; i < 8; i++) begin
			fifo[i] = 8'h5A ^ 8'(i * 37);
			rev[i] = 8'hC3 ^ 8'(i * 29);
		end
		repeat (10) @(negedge clk);
		chk({stb_n, stb_oe_b, afd_n, afd_oe_b, epp_w_n, tx_ready, rx_valid, 1'b0}, 8'hF8);
		chk(d_oe_b, 8'hFF);
		rst_b = 1'b1;
		t_fault();
		t_ecp_fwd();
		t_compat();
		t_rev();
		mode = eph_pkg::MODE_EPP;
		repeat (2) @(negedge clk);
		chk({7'h00, epp_w_n}, 8'h01);
		dir = 1'b0;
		repeat (2) @(negedge clk);
		chk({7'h00, epp_w_n}, 8'h00);
		wrap_up();
	end
endmodule
